/* design/flash_program_erase_regs.sv */
// software register set and operation sequencer of the flash controller
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs_defs.svh"

module flash_program_erase_regs #(
  parameter logic [31:0] ARRAY_UNLOCK_VALUE = 32'h1234_5678,
  parameter logic [31:0] ARRAY_UNLOCK_VALUE2 = 32'h9abc_def0,
  parameter logic [31:0] OPTION_UNLOCK_VALUE = 32'h1234_5678,
  parameter logic [31:0] OPTION_UNLOCK_VALUE2 = 32'h9abc_def0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port
  input wire flash_regs_pkg::reg_req_t req_in,
  output logic [31:0] rdata_out,
  // option bytes loaded at reset, stable while srst_in high
  input wire flash_regs_pkg::option_image_t option_image_in,
  // flash array side: old contents of the target word
  input wire logic [15:0] array_rdata_in,
  // flash array side: operation strobes
  output logic array_prog_out,
  output logic array_erase_out,
  output logic [31:0] array_addr_out,
  // interrupt line to the core
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////

  flash_regs_pkg::op_state_t state_r;
  logic [31:0] control_r;
  logic busy_r;
  logic prog_err_r;
  logic prot_err_r;
  logic done_r;
  logic [31:0] address_r;
  logic [31:0] option_status_r;
  logic [31:0] protect_r;
  logic [1:0] unlock_step_r;
  logic [1:0] opt_step_r;
  logic [7:0] cycle_cnt_r;
  logic [7:0] cycle_cnt_nxt;
  logic [15:0] array_rdata_s1_r;
  logic [15:0] array_rdata_s2_r;
  logic op_selected;
  logic op_allowed;
  logic finish;
  logic wr_ctl;
  logic wr_sts;
  logic [31:0] next_control;
  logic is_prog;
  logic prot_fail;
  logic prog_fail;
  logic check_fail;
  flash_regs_pkg::option_image_t option_s1_r;
  flash_regs_pkg::option_image_t option_s2_r;

  // pick erased value when byte and complement disagree, flagging error unless both read erased
  function automatic logic byte_bad(input logic [7:0] b, input logic [7:0] bn);
    byte_bad = ((b ^ bn) != 8'hff) && !(b == `ERASED_BYTE && bn == `ERASED_BYTE);
  endfunction

  function automatic logic [7:0] byte_pick(input logic [7:0] b, input logic [7:0] bn);
    byte_pick = byte_bad(b, bn) ? `ERASED_BYTE : b;
  endfunction

  // request passed in so a continuous assign sees every change of it
  function automatic logic hit(input flash_regs_pkg::reg_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // protect bit of the 4KB group holding an address; zero means guarded
  function automatic logic group_open(input logic [31:0] prot, input logic [31:0] a);
    group_open = prot[a[`GROUP_LSB +: 5]];
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign wr_ctl = hit(req_in, `OFS_CONTROL);
  assign wr_sts = hit(req_in, `OFS_STATUS);
  assign op_selected = |{control_r[`CTL_PROG], control_r[`CTL_PAGE_ERASE], control_r[`CTL_MASS_ERASE],
                         control_r[`CTL_OPT_PROG], control_r[`CTL_OPT_ERASE]};
  assign op_allowed = !(control_r[`CTL_OPT_PROG] || control_r[`CTL_OPT_ERASE]) || control_r[`CTL_OPT_WEN];
  assign finish = (state_r == flash_regs_pkg::ST_RUN) && (cycle_cnt_r == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // checks made in the cycle after busy rises

  assign is_prog = control_r[`CTL_PROG];
  assign prot_fail = is_prog && !group_open(protect_r, address_r);
  // synced word trails a fresh address by three cycles, so a start written in the next cycle is checked against the old word
  assign prog_fail = is_prog && (array_rdata_s2_r != `ERASED_HALF);
  // one term for every abort, so start and busy fall together
  assign check_fail = prot_fail || prog_fail || !op_allowed;

  // lock only settable; locked writes ignored
  always_comb begin
    next_control = control_r;
    if (wr_ctl) begin
      if (!control_r[`CTL_LOCK]) begin
        next_control = (control_r & ~`CTL_WRITE_MASK) | (req_in.wdata & `CTL_WRITE_MASK);
        next_control[`CTL_START] = control_r[`CTL_START] | req_in.wdata[`CTL_START];
      end
      next_control[`CTL_LOCK] = control_r[`CTL_LOCK] | req_in.wdata[`CTL_LOCK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key sequences: two words in order unlock

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      unlock_step_r <= 2'h0;
    end else if (hit(req_in, `OFS_ARRAY_KEY)) begin
      if (unlock_step_r == 2'h0 && req_in.wdata == ARRAY_UNLOCK_VALUE) begin
        unlock_step_r <= 2'h1;
      end else if (unlock_step_r == 2'h1 && req_in.wdata == ARRAY_UNLOCK_VALUE2) begin
        unlock_step_r <= 2'h2;
      end else begin
        unlock_step_r <= 2'h0;
      end
    end else if (unlock_step_r == 2'h2) begin
      unlock_step_r <= 2'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      opt_step_r <= 2'h0;
    end else if (hit(req_in, `OFS_OPTION_KEY)) begin
      if (opt_step_r == 2'h0 && req_in.wdata == OPTION_UNLOCK_VALUE) begin
        opt_step_r <= 2'h1;
      end else if (opt_step_r == 2'h1 && req_in.wdata == OPTION_UNLOCK_VALUE2) begin
        opt_step_r <= 2'h2;
      end else begin
        opt_step_r <= 2'h0;
      end
    end else if (opt_step_r == 2'h2) begin
      opt_step_r <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      control_r <= `CONTROL_RESET;
    end else begin
      control_r <= next_control;
      if (unlock_step_r == 2'h2) begin
        control_r[`CTL_LOCK] <= 1'b0;
      end
      if (opt_step_r == 2'h2 && !control_r[`CTL_LOCK]) begin
        control_r[`CTL_OPT_WEN] <= 1'b1;
      end
      // start drops with busy, on an abort too, else idle would start again
      if (finish || (state_r == flash_regs_pkg::ST_CHECK && check_fail)) begin
        control_r[`CTL_START] <= 1'b0;
      end
    end
  end

  // array data crosses from the flash macro domain
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      array_rdata_s1_r <= 16'h0000;
      array_rdata_s2_r <= 16'h0000;
    end else begin
      array_rdata_s1_r <= array_rdata_in;
      array_rdata_s2_r <= array_rdata_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer

  always_comb begin
    cycle_cnt_nxt = cycle_cnt_r;
    if (state_r == flash_regs_pkg::ST_RUN && cycle_cnt_r != 8'h00) begin
      cycle_cnt_nxt = cycle_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= flash_regs_pkg::ST_IDLE;
      busy_r <= 1'b0;
      cycle_cnt_r <= 8'h00;
      array_prog_out <= 1'b0;
      array_erase_out <= 1'b0;
    end else begin
      cycle_cnt_r <= cycle_cnt_nxt;
      array_prog_out <= 1'b0;
      array_erase_out <= 1'b0;
      case (state_r)
        flash_regs_pkg::ST_IDLE: begin
          if (control_r[`CTL_START] && op_selected) begin
            busy_r <= 1'b1;
            state_r <= flash_regs_pkg::ST_CHECK;
          end
        end
        flash_regs_pkg::ST_CHECK: begin
          if (prot_fail) begin
            busy_r <= 1'b0;
            state_r <= flash_regs_pkg::ST_IDLE;
          end else if (prog_fail) begin
            busy_r <= 1'b0;
            state_r <= flash_regs_pkg::ST_IDLE;
          end else if (!op_allowed) begin
            busy_r <= 1'b0;
            state_r <= flash_regs_pkg::ST_IDLE;
          end else begin
            state_r <= flash_regs_pkg::ST_RUN;
            array_prog_out <= control_r[`CTL_PROG] | control_r[`CTL_OPT_PROG];
            array_erase_out <= ~(control_r[`CTL_PROG] | control_r[`CTL_OPT_PROG]);
            cycle_cnt_r <= (control_r[`CTL_PROG] | control_r[`CTL_OPT_PROG]) ?
                           8'(`PROG_CYCLES) : 8'(`ERASE_CYCLES);
          end
        end
        flash_regs_pkg::ST_RUN: begin
          if (finish) begin
            busy_r <= 1'b0;
            state_r <= flash_regs_pkg::ST_IDLE;
          end
        end
        default: begin
          busy_r <= 1'b0;
          state_r <= flash_regs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over software write-one clear

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prog_err_r <= 1'b0;
      prot_err_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (wr_sts && req_in.wdata[`STS_PROG_ERR]) begin
        prog_err_r <= 1'b0;
      end
      if (wr_sts && req_in.wdata[`STS_PROT_ERR]) begin
        prot_err_r <= 1'b0;
      end
      if (wr_sts && req_in.wdata[`STS_DONE]) begin
        done_r <= 1'b0;
      end
      if (state_r == flash_regs_pkg::ST_CHECK && control_r[`CTL_PROG]) begin
        if (!protect_r[address_r[`GROUP_LSB +: 5]]) begin
          prot_err_r <= 1'b1;
        end else if (array_rdata_s2_r != `ERASED_HALF) begin
          prog_err_r <= 1'b1;
        end
      end
      if (finish) begin
        done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      address_r <= `ADDRESS_RESET;
      array_addr_out <= `ADDRESS_RESET;
    end else begin
      if (hit(req_in, `OFS_ADDRESS) && !busy_r) begin
        address_r <= req_in.wdata;
      end
      array_addr_out <= address_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option load, captured during reset

  // image arrives from the array loader; two stages before anything reads it
  always_ff @(posedge clk_in) begin
    option_s1_r <= option_image_in;
    option_s2_r <= option_s1_r;
  end

  // loaded bytes
  // limitation: reset must stand three edges for a clean capture
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      option_status_r <= `OPT_STATUS_RESET;
      option_status_r[`OPT_ERR_BIT] <= byte_bad(option_s2_r.rdp, option_s2_r.rdp_n) |
                                        byte_bad(option_s2_r.user, option_s2_r.user_n) |
                                        byte_bad(option_s2_r.user_byte_zero, option_s2_r.user_byte_zero_n) |
                                        byte_bad(option_s2_r.user_byte_one, option_s2_r.user_byte_one_n);
      option_status_r[`OPT_RDP_BIT] <= byte_pick(option_s2_r.rdp, option_s2_r.rdp_n) != `RDP_OPEN_CODE;
      option_status_r[`OPT_USER_LSB +: 8] <= byte_pick(option_s2_r.user, option_s2_r.user_n);
      option_status_r[`OPT_USER_BYTE_ZERO_LSB +: 8] <= byte_pick(option_s2_r.user_byte_zero, option_s2_r.user_byte_zero_n);
      option_status_r[`OPT_USER_BYTE_ONE_LSB +: 8] <= byte_pick(option_s2_r.user_byte_one, option_s2_r.user_byte_one_n);
      protect_r <= option_s2_r.protect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (control_r[`CTL_ERR_IE] & (prog_err_r | prot_err_r)) | (control_r[`CTL_DONE_IE] & done_r);
    end
  end

  // key registers read zero; unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= 32'h0000_0000;
      if (req_in.rd) begin
        case (req_in.addr)
          `OFS_STATUS: begin
            rdata_out[`STS_BUSY] <= busy_r;
            rdata_out[`STS_PROG_ERR] <= prog_err_r;
            rdata_out[`STS_PROT_ERR] <= prot_err_r;
            rdata_out[`STS_DONE] <= done_r;
          end
          `OFS_CONTROL: begin
            rdata_out <= control_r;
          end
          `OFS_ADDRESS: begin
            rdata_out <= address_r;
          end
          `OFS_OPTION_STATUS: begin
            rdata_out <= option_status_r;
          end
          `OFS_PROTECT_STATUS: begin
            rdata_out <= protect_r;
          end
          default: begin
            rdata_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* design/flash_regs_defs.svh */
// register offsets, field positions, reset values and timing counts
//
// Functional notes
// - array unlock key register is write-only; correct key unlocks; reads return zero.
// - option unlock key register is write-only; correct key enables option writes; reads zero.
// - busy flag, status bit 0, high while program or erase runs.
// - program error flag, status bit 2, when target word was not erased.
// - protect error flag, status bit 4, when programming a protected address.
// - completion flag, status bit 5, set each time an operation finishes.
// - control bit 0 selects array program, bit 4 option program.
// - control bit 1 page erase, bit 2 mass erase, bit 5 option erase.
// - start bit 6 only set by software; cleared when busy clears.
// - lock bit 7 accepts only ones, locks control register, resets to one.
// - option programming allowed only while option write enable bit 9 set.
// - error interrupt enable bit 10 raises interrupt while either error flag set.
// - completion interrupt enable bit 12 raises interrupt while completion flag set.
// - address register updated by hardware to the address in use or last used; the code loads it only from software writes made while not busy.
// - option error bit 0 when byte mismatches complement; both bytes forced erased; the code flags no error when byte and complement are both erased.
// - option status bit 1 shows read protection active.
// - user option byte at 9:2, user data bytes at 17:10 and 25:18.
// - option status contents come from option bytes loaded at reset.
// - write protect status register read-only, zero means protected, resets all ones; the code loads the option image protect word at reset instead.
// - each protect bit guards two consecutive 2KB pages; cleared bit protects.
`ifndef FLASH_REGS_DEFS_SVH
`define FLASH_REGS_DEFS_SVH

`define OFS_ARRAY_KEY 8'h04
`define OFS_OPTION_KEY 8'h08
`define OFS_STATUS 8'h0c
`define OFS_CONTROL 8'h10
`define OFS_ADDRESS 8'h14
`define OFS_OPTION_STATUS 8'h1c
`define OFS_PROTECT_STATUS 8'h20

`define STS_BUSY 0
`define STS_PROG_ERR 2
`define STS_PROT_ERR 4
`define STS_DONE 5

`define CTL_PROG 0
`define CTL_PAGE_ERASE 1
`define CTL_MASS_ERASE 2
`define CTL_OPT_PROG 4
`define CTL_OPT_ERASE 5
`define CTL_START 6
`define CTL_LOCK 7
`define CTL_OPT_WEN 9
`define CTL_ERR_IE 10
`define CTL_DONE_IE 12
`define CTL_WRITE_MASK 32'h0000_1637

`define CONTROL_RESET 32'h0000_0080
`define STATUS_RESET 32'h0000_0000
`define ADDRESS_RESET 32'h0000_0000
`define PROTECT_RESET 32'h ffff_ffff

`define OPT_ERR_BIT 0
`define OPT_RDP_BIT 1
`define OPT_USER_LSB 2
`define OPT_USER_BYTE_ZERO_LSB 10
`define OPT_USER_BYTE_ONE_LSB 18
`define OPT_STATUS_RESET 32'h03ff_fffc
`define RDP_OPEN_CODE 8'ha5
`define ERASED_BYTE 8'hff
`define ERASED_HALF 16'hffff

// page index lsb: 2KB pages; protect group is page/2
`define PAGE_LSB 11
`define GROUP_LSB 12

// operation durations in ns, converted to cycles at 4 ns
`define CLK_PERIOD_NS 4
`define PROG_TIME_NS 40
`define ERASE_TIME_NS 400
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* design/flash_regs_pkg.sv */
// types shared by the flash register block
package flash_regs_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // raw option bytes and their complements as loaded from the array
  typedef struct packed {
    logic [7:0] rdp;
    logic [7:0] rdp_n;
    logic [7:0] user;
    logic [7:0] user_n;
    logic [7:0] user_byte_zero;
    logic [7:0] user_byte_zero_n;
    logic [7:0] user_byte_one;
    logic [7:0] user_byte_one_n;
    logic [31:0] protect;
    logic [31:0] protect_n;
  } option_image_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_RUN = 3'b100
  } op_state_t;

endpackage

/* tb/flash_array_model.sv */
// behavioural flash array: program clears a word, any erase restores all
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  // clock
  input wire logic clk_in,
  // controller strobes and address
  input wire logic prog_in,
  input wire logic erase_in,
  input wire logic [31:0] addr_in,
  // old contents of the addressed word
  output logic [15:0] rdata_out
);
  // flash keeps its contents over reset, so no reset here
  logic [15:0] used_r = 16'h0000;
  always_ff @(posedge clk_in) begin
    if (erase_in) begin
      used_r <= 16'h0000;
    end else if (prog_in) begin
      used_r[addr_in[4:1]] <= 1'b1;
    end
  end
  assign rdata_out = used_r[addr_in[4:1]] ? 16'h0000 : 16'hffff;
endmodule
`default_nettype wire

/* tb/flash_program_erase_regs_checker.sv */
// port assertions for the flash register block
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_regs_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // watched ports
  input wire flash_regs_pkg::reg_req_t req_in,
  input wire logic [31:0] rdata_out,
  input wire flash_regs_pkg::option_image_t option_image_in,
  input wire logic array_prog_out,
  input wire logic array_erase_out
);
  flash_regs_pkg::option_image_t img_r;
  // image as seen at the last reset edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      img_r <= option_image_in;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence rd_at(logic [7:0] a);
    req_in.rd && req_in.addr == a;
  endsequence
  // no second strobe in the eight cycles after a strobe
  sequence quiet_s;
    (!array_prog_out && !array_erase_out) [*8];
  endsequence
  a_rdata_idle_zero: assert property (!$past(req_in.rd) |-> rdata_out == 32'h0)
    else $error("read data outside a read cycle");
  a_key_reads_zero: assert property (rd_at(8'h04) |=> rdata_out == 32'h0)
    else $error("array key read not zero");
  a_optkey_reads_zero: assert property (rd_at(8'h08) |=> rdata_out == 32'h0)
    else $error("option key read not zero");
  a_status_bits_only: assert property (rd_at(8'h0c) |=> (rdata_out & 32'hffff_ffca) == 32'h0)
    else $error("status reserved bit set");
  a_control_bits_only: assert property (rd_at(8'h10) |=> (rdata_out & 32'hffff_e908) == 32'h0)
    else $error("control reserved bit set");
  a_protect_from_image: assert property (rd_at(8'h20) |=> rdata_out == img_r.protect)
    else $error("protect status differs from image");
  a_read_protect_bit: assert property (rd_at(8'h1c) |=>
    rdata_out[1] == !(img_r.rdp == 8'ha5 && img_r.rdp_n == 8'h5a))
    else $error("read protect bit wrong");
  a_prog_then_quiet: assert property (array_prog_out |=> quiet_s)
    else $error("strobe during program");
  a_erase_then_quiet: assert property (array_erase_out |=> quiet_s)
    else $error("strobe during erase");
endmodule
bind flash_program_erase_regs flash_program_erase_regs_checker i_checker (
  .clk_in(clk_in),
  .srst_in(srst_in),
  .req_in(req_in),
  .rdata_out(rdata_out),
  .option_image_in(option_image_in),
  .array_prog_out(array_prog_out),
  .array_erase_out(array_erase_out)
);
`default_nettype wire

/* tb/flash_program_erase_regs_tb.sv */
// register-level testbench of the flash register block
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs_defs.svh"
module flash_program_erase_regs_tb;
  // key values arbitrary
  localparam logic [31:0] K1 = 32'h1234_5678;
  localparam logic [31:0] K2 = 32'h9abc_def0;
  localparam flash_regs_pkg::option_image_t IMG_A = '{rdp: 8'ha5, rdp_n: 8'h5a, user: 8'h05, user_n: 8'hfa,
    user_byte_zero: 8'h3c, user_byte_zero_n: 8'hc3, user_byte_one: 8'h81, user_byte_one_n: 8'h7e, protect: 32'hffff_fffe, protect_n: 32'h1};
  localparam flash_regs_pkg::option_image_t IMG_B = '{rdp: 8'hff, rdp_n: 8'hff, user: 8'h05, user_n: 8'hfa,
    user_byte_zero: 8'h3c, user_byte_zero_n: 8'h00, user_byte_one: 8'h81, user_byte_one_n: 8'h7e, protect: 32'hffff_ffff, protect_n: 32'h0};
  logic clk_in;
  logic srst_in = 1'b1;
  flash_regs_pkg::reg_req_t req = '0;
  flash_regs_pkg::option_image_t img = IMG_A;
  logic [31:0] rdata;
  logic [15:0] arr_rdata;
  logic prog;
  logic erase;
  logic [31:0] arr_addr;
  logic irq;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] t_addr [9] = '{32'h2002, 32'h2002, 32'h0804, 32'h2002, 32'h1002, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] t_ctrl [9] = '{32'h1401, 32'h1401, 32'h1401, 32'h1402, 32'h0001, 32'h1404, 32'h1610, 32'h1620,
    32'h1410};
  logic [31:0] t_st [9] = '{32'h20, 32'h04, 32'h10, 32'h20, 32'h20, 32'h20, 32'h20, 32'h20, 32'h00};

  flash_program_erase_regs #(.ARRAY_UNLOCK_VALUE(K1), .ARRAY_UNLOCK_VALUE2(K2), .OPTION_UNLOCK_VALUE(K1),
    .OPTION_UNLOCK_VALUE2(K2)) i_flash_program_erase_regs (.clk_in(clk_in), .srst_in(srst_in), .req_in(req),
    .rdata_out(rdata), .option_image_in(img), .array_rdata_in(arr_rdata), .array_prog_out(prog),
    .array_erase_out(erase), .array_addr_out(arr_addr), .irq_out(irq));
  flash_array_model i_flash_array_model (.clk_in(clk_in), .prog_in(prog), .erase_in(erase),
    .addr_in(arr_addr), .rdata_out(arr_rdata));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // every access leaves one idle cycle so no strobe is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_in);
    req.wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_in);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic do_reset();
    srst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic op(input logic [31:0] a, input logic [31:0] c, input logic [31:0] st);
    logic [31:0] d;
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    wr(`OFS_ADDRESS, a);
    wr(`OFS_CONTROL, c);
    wr(`OFS_CONTROL, c | 32'h40);
    // let an aborted operation settle before polling
    repeat (3) @(posedge clk_in);
    do begin
      rd(`OFS_STATUS, d);
      seen = seen | d[0];
      n++;
    end while (d[0] === 1'b1 && n < 100);
    chk(d, st);
    if (st[5]) chk({31'h0, seen}, 32'h1);
    rchk(`OFS_CONTROL, c);
    rchk(`OFS_ADDRESS, a);
    chk(arr_addr, a);
    chk({31'h0, irq}, {31'h0, (c[10] & (st[2] | st[4])) | (c[12] & st[5])});
    wr(`OFS_STATUS, 32'h34);
    rchk(`OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    rchk(`OFS_STATUS, 32'h0);
    rchk(`OFS_CONTROL, 32'h80);
    rchk(`OFS_ADDRESS, 32'h0);
    rchk(`OFS_OPTION_STATUS, {6'h0, 8'h81, 8'h3c, 8'h05, 2'b00});
    rchk(`OFS_PROTECT_STATUS, IMG_A.protect);
    rchk(`OFS_ARRAY_KEY, 32'h0);
    rchk(`OFS_OPTION_KEY, 32'h0);
    rchk(8'h18, 32'h0);
    wr(`OFS_PROTECT_STATUS, 32'h0);
    rchk(`OFS_PROTECT_STATUS, IMG_A.protect);
    $display("test reset values done");
    wr(`OFS_CONTROL, 32'h1641);
    repeat (4) @(posedge clk_in);
    rchk(`OFS_STATUS, 32'h0);
    rchk(`OFS_CONTROL, 32'h80);
    wr(`OFS_ARRAY_KEY, K1);
    wr(`OFS_ARRAY_KEY, K2);
    rchk(`OFS_CONTROL, 32'h0);
    $display("test lock done");
    for (int i = 0; i < 9; i++) begin
      if (i == 6) begin
        wr(`OFS_OPTION_KEY, K1);
        wr(`OFS_OPTION_KEY, K2);
        rchk(`OFS_CONTROL, 32'h0000_1604);
      end
      op(t_addr[i], t_ctrl[i], t_st[i]);
      $display("test op %0d done", i);
    end
    wr(`OFS_CONTROL, 32'h80);
    rchk(`OFS_CONTROL, 32'h80);
    img <= IMG_B;
    do_reset();
    rchk(`OFS_OPTION_STATUS, {6'h0, 8'h81, 8'hff, 8'h05, 2'b11});
    rchk(`OFS_PROTECT_STATUS, 32'hffff_ffff);
    $display("test option error done");
    test_done();
  end
  initial begin
    #160000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
